// ==== bench/ctsim_chk.sv ====
// Port checker of the camera simulator control block
`default_nettype none
module ctsim_chk (
   input wire logic hclk,
   input wire logic hresetn,
   input wire logic hsel,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic hready,
   input wire logic hreadyout,
   input wire logic hresp,
   input wire logic [31:0] hrdata,
   input wire logic ser_from_grabber,
   input wire logic ser_to_grabber,
   input wire logic fifo_flush,
   input wire logic running,
   input wire logic line_valid,
   input wire logic frame_valid
);
   timeunit 1ns;
   timeprecision 1ns;
   // ----------
   // Assertions
   // ----------
   default clocking @(posedge hclk);
   endclocking
   default disable iff (!hresetn);
   sequence s_halted;
      fifo_flush [*3];
   endsequence
   a_bus_okay: assert property (hreadyout && !hresp) else $error("bus answer not okay");
   a_rdata_hold: assert property (!(hsel && hready && htrans[1] && !hwrite) |=> $stable(hrdata))
      else $error("read data moved");
   a_halt_idle: assert property (s_halted |-> !running && !line_valid && !frame_valid)
      else $error("active while halted");
   a_halt_enter: assert property ($rose(fifo_flush) |-> ##[0:2] !running)
      else $error("no halt");
   a_start_run: assert property ($fell(fifo_flush) |-> ##[0:4] running)
      else $error("no start");
   a_echo_path: assert property (ser_to_grabber || !$past(ser_from_grabber, 3))
      else $error("bad echo");
   a_line_run: assert property ($rose(line_valid) |-> running)
      else $error("line while stopped");
   a_frame_run: assert property ($rose(frame_valid) |-> running)
      else $error("frame while stopped");
endmodule
bind ctsim_ctrl ctsim_chk chk_u (.hclk, .hresetn, .hsel, .htrans, .hwrite, .hready, .hreadyout,
   .hresp, .hrdata, .ser_from_grabber, .ser_to_grabber, .fifo_flush, .running, .line_valid,
   .frame_valid);
`default_nettype wire

// ==== bench/ctsim_fg_model.sv ====
// Framegrabber model driving the control lines and the serial line
`default_nettype none
module ctsim_fg_model (
   input wire logic hclk,
   input wire logic ser_to_grabber,
   output logic cam_ctrl1 = 1'b0,
   output logic cam_ctrl2 = 1'b0,
   output logic ser_from_grabber = 1'b1
);
   timeunit 1ns;
   timeprecision 1ns;
   // ----------
   // Line driver
   // ----------
   task drive(input logic c1, input logic c2, input logic s);
      @(posedge hclk);
      cam_ctrl1 <= c1;
      cam_ctrl2 <= c2;
      ser_from_grabber <= s;
   endtask
endmodule
`default_nettype wire

// ==== bench/tb.sv ====
// Testbench of the camera simulator control block
`include "ctsim_defines.vh"
`default_nettype none
module tb;
   timeunit 1ns;
   timeprecision 1ns;
   logic hclk = 1'b0, hresetn = 1'b0, hsel = 1'b0, hwrite = 1'b0, pix_we = 1'b0;
   logic [31:0] haddr = 32'h0, hwdata = 32'h0, r, prev;
   logic [1:0] htrans = 2'b00;
   logic [2:0] hsize = 3'b010;
   logic [11:0] pix_waddr = 12'h0;
   logic [7:0] pix_wdata = 8'h0;
   wire cam_ctrl1, cam_ctrl2, ser_from_grabber, hreadyout, hresp, ser_to_grabber;
   wire fifo_flush, running, line_valid, frame_valid;
   wire hready = hreadyout;
   wire [31:0] hrdata, pix_data;
   int n_mismatch = 0;
   int tests_run = 0;
   logic [11:0] inc [4] = '{12'h1, 12'h3, 12'h5, 12'hFFF};
   logic [72:0] rows [8] = '{{1'b0, `CTSIM_OFF_CFG, 32'h0, 32'h8},
      {1'b0, `CTSIM_OFF_TRIG, 32'h0, 32'h1}, {1'b0, `CTSIM_OFF_UART, 32'h0, 32'h0},
      {1'b0, `CTSIM_OFF_STATUS, 32'h0, 32'h3}, {1'b1, 8'h20, 32'hFFFF_FFFF, 32'h0},
      {1'b1, `CTSIM_OFF_TAP3, 32'hFFFF_FFFF, 32'h0FFF_0FFF},
      {1'b1, `CTSIM_OFF_TAP0, 32'h0003_0005, 32'h0003_0005},
      {1'b1, `CTSIM_OFF_TRIG, 32'h2, 32'h2}};
   ctsim_ctrl dut_u (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata, .hready,
      .hreadyout, .hresp, .hrdata, .cam_ctrl1, .cam_ctrl2, .ser_from_grabber, .ser_to_grabber,
      .pix_we, .pix_waddr, .pix_wdata, .fifo_flush, .running, .line_valid, .frame_valid,
      .pix_data);
   ctsim_fg_model fg_u (.hclk, .ser_to_grabber, .cam_ctrl1, .cam_ctrl2, .ser_from_grabber);
   initial begin
      forever #10 hclk = ~hclk;
   end
   // ----------
   // Bus and check tasks
   // ----------
   task test_done;
      if (n_mismatch == 0 && tests_run > 0) $display("TEST PASSED");
      else $display("TEST FAILED");
      $finish;
   endtask
   task chk(input string nm, input logic [31:0] e, input logic [31:0] s);
      tests_run++;
      if (s !== e) begin
         n_mismatch++;
         $display("CHECK FAILED %s expected %h seen %h", nm, e, s);
      end
   endtask
   task wait_hi(input bit lv);
      int i;
      i = 0;
      do begin
         @(posedge hclk);
         i++;
      end while ((lv ? line_valid : hreadyout) !== 1'b1 && i < 200);
      if ((lv ? line_valid : hreadyout) !== 1'b1) begin
         chk("wait", 32'h1, 32'h0);
         test_done;
      end
   endtask
   task ahb(input bit w, input logic [7:0] a, input logic [31:0] d);
      @(posedge hclk);
      hsel <= 1'b1;
      htrans <= 2'b10;
      hwrite <= w;
      haddr <= {24'h0, a};
      wait_hi(0);
      hsel <= 1'b0;
      htrans <= 2'b00;
      hwdata <= d;
      wait_hi(0);
      r = hrdata;
   endtask
   initial begin
      repeat (2) @(posedge hclk);
      hresetn <= 1'b1;
      foreach (rows[k]) begin
         if (rows[k][72]) ahb(1, rows[k][71:64], rows[k][63:32]);
         ahb(0, rows[k][71:64], 0);
         chk("register", rows[k][31:0], r);
      end
      for (int a = 0; a < 4096; a++) begin
         @(posedge hclk);
         pix_we <= 1'b1;
         pix_waddr <= a[11:0];
         pix_wdata <= a[7:0];
      end
      @(posedge hclk);
      pix_we <= 1'b0;
      for (int i = 0; i < 4; i++) ahb(1, 8'(`CTSIM_OFF_TAP0 + 4 * i), {4'h0, inc[i], 16'(16 * i)});
      ahb(1, `CTSIM_OFF_CFG, 0);
      wait_hi(1);
      repeat (4) @(posedge hclk);
      prev = pix_data;
      for (int i = 0; i < 4; i++) begin
         chk("tap_base", 32'(8'(16 * i + 3 * inc[i])), 32'(prev[8*i+:8]));
      end
      repeat (12) begin
         @(posedge hclk);
         for (int i = 0; i < 4; i++) begin
            r = 32'(8'(pix_data[8*i+:8] - prev[8*i+:8]));
            chk("tap", 32'(inc[i][7:0]), r);
         end
         prev = pix_data;
      end
      for (int m = 0; m < 2; m++) begin
         ahb(1, `CTSIM_OFF_UART, m);
         for (int b = 0; b < 4; b++) begin
            fg_u.drive(1'b0, 1'b0, b[0]);
            repeat (5) @(posedge hclk);
            chk("echo", 32'(m ? b[0] : 1'b1), 32'(ser_to_grabber));
         end
      end
      for (int k = 0; k < 8; k++) begin
         ahb(1, `CTSIM_OFF_CFG, 32'h8);
         fg_u.drive(!k[0], !k[0], 1'b1);
         ahb(1, `CTSIM_OFF_TRIG, {28'h0, k[2], !k[2], k[1], k[0]});
         ahb(1, `CTSIM_OFF_CFG, 0);
         fg_u.drive(k[0] ~^ k[1], k[0] ^ k[1], 1'b1);
         repeat (10) @(posedge hclk);
         chk("hold", 32'h0, 32'(line_valid));
         chk("flush_off", 32'h0, 32'(fifo_flush));
         fg_u.drive(k[0] ^ k[1], k[0] ~^ k[1], 1'b1);
         wait_hi(1);
         chk("trigger", 32'h1, 32'(line_valid));
         chk("frame", 32'h1, 32'(frame_valid));
      end
      ahb(1, `CTSIM_OFF_CFG, 32'h8);
      repeat (4) @(posedge hclk);
      chk("halt", 32'h0, 32'({running, line_valid, frame_valid}));
      chk("flush_on", 32'h1, 32'(fifo_flush));
      hresetn <= 1'b0;
      repeat (2) @(posedge hclk);
      hresetn <= 1'b1;
      ahb(0, `CTSIM_OFF_TRIG, 0);
      chk("trig_reset", 32'h1, r);
      test_done;
   end
endmodule
`default_nettype wire

// ==== design/ctsim_ctrl.v ====
// Camera simulator control: trigger, serial echo, tap interleave, start/stop
`include "ctsim_defines.vh"
`default_nettype none
// How it works
// - Polarity bit 1 (reset value) means high trigger active; 0 means low active.
// - Source bit set takes trigger from control line 2, clear from line 1.
// - Serial loopback enabled echoes each received serial bit unchanged; else idle high.
// - Four taps each hold own programmable start address and increment.
// - Start address is 12 bits, indexing 4096 8-bit raster pixels.
// - Every pixel clock each tap address adds its increment.
// - Writing configuration with bit 3 clear releases the FIFO flush and starts simulator.
// - Setting bit 3 of configuration halts frame generation until cleared.
// - Frame trigger mode waits at each frame start for a new edge into the active trigger level.
// - Line trigger mode waits at each line start for a new edge into the active trigger level.
module ctsim_ctrl #(
   parameter AW = 12,
   parameter TAPS = 4
) (
   input wire hclk,
   input wire hresetn,
   input wire hsel,
   input wire [31:0] haddr,
   input wire [1:0] htrans,
   input wire hwrite,
   input wire [2:0] hsize,
   input wire [31:0] hwdata,
   input wire hready,
   output reg hreadyout,
   output reg hresp,
   output reg [31:0] hrdata,
   input wire cam_ctrl1,
   input wire cam_ctrl2,
   input wire ser_from_grabber,
   output reg ser_to_grabber,
   input wire pix_we,
   input wire [AW-1:0] pix_waddr,
   input wire [7:0] pix_wdata,
   output reg fifo_flush,
   output reg running,
   output reg line_valid,
   output reg frame_valid,
   output reg [TAPS*8-1:0] pix_data
);
   // ------------------------------------------------------------
   // Bus slave
   // ------------------------------------------------------------
   reg [7:0] cfg_r;
   reg [3:0] trig_r;
   reg uart_r;
   reg [TAPS*AW-1:0] start_r;
   reg [TAPS*AW-1:0] inc_r;
   reg [15:0] line_len_r;
   reg [15:0] frame_lines_r;
   reg wr_pend_r;
   reg [7:0] wr_addr_r;
   wire take = hsel & hready & htrans[1];
   wire [TAPS*8-1:0] mem_rdata;
   reg [TAPS*AW-1:0] addr_r;
   reg [2:0] state_r;
   reg trig_seen_r;
   reg [15:0] pix_cnt_r;
   reg [15:0] line_cnt_r;
   reg [31:0] rd_nxt;
   integer k;
   integer wr_k;
   integer adv_k;
   always @* begin
      rd_nxt = 32'h0000_0000;
      case (haddr[7:0])
         `CTSIM_OFF_CFG: rd_nxt = {24'h00_0000, cfg_r};
         `CTSIM_OFF_TRIG: rd_nxt = {28'h000_0000, trig_r};
         `CTSIM_OFF_UART: rd_nxt = {31'h0000_0000, uart_r};
         `CTSIM_OFF_STATUS: rd_nxt = {26'h000_0000, trig_seen_r, running, state_r, fifo_flush};
         default: begin
            for (k = 0; k < TAPS; k = k + 1) begin
               if (haddr[7:0] == `CTSIM_OFF_TAP0 + k*4) begin
                  rd_nxt = {4'h0, inc_r[k*AW +: AW], 4'h0, start_r[k*AW +: AW]};
               end
            end
         end
      endcase
   end
   always @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         hreadyout <= 1'b1;
         hresp <= 1'b0;
         hrdata <= 32'h0000_0000;
         wr_pend_r <= 1'b0;
         wr_addr_r <= 8'h00;
         cfg_r <= `CTSIM_CFG_RESET_VAL;
         trig_r <= `CTSIM_TRIG_RESET_VAL;
         uart_r <= 1'b0;
         start_r <= {TAPS*AW{1'b0}};
         inc_r <= {TAPS*AW{1'b0}};
         line_len_r <= `CTSIM_LINE_LEN_DEF;
         frame_lines_r <= `CTSIM_FRAME_LINES_DEF;
      end else begin
         wr_pend_r <= take & hwrite;
         if (take) begin
            wr_addr_r <= haddr[7:0];
            if (!hwrite) begin
               hrdata <= rd_nxt;
            end
         end
         if (wr_pend_r) begin
            case (wr_addr_r)
               `CTSIM_OFF_CFG: cfg_r <= hwdata[7:0];
               `CTSIM_OFF_TRIG: trig_r <= hwdata[3:0];
               `CTSIM_OFF_UART: uart_r <= hwdata[`CTSIM_UART_LOOP];
               default: begin
                  for (wr_k = 0; wr_k < TAPS; wr_k = wr_k + 1) begin
                     if (wr_addr_r == `CTSIM_OFF_TAP0 + wr_k*4) begin
                        start_r[wr_k*AW +: AW] <= hwdata[`CTSIM_TAP_START_LSB +: AW];
                        inc_r[wr_k*AW +: AW] <= hwdata[`CTSIM_TAP_INC_LSB +: AW];
                     end
                  end
               end
            endcase
         end
      end
   end
   // ------------------------------------------------------------
   // Trigger and serial input synchronisers
   // ------------------------------------------------------------
   reg [1:0] cc1_s;
   reg [1:0] cc2_s;
   reg [1:0] ser_s;
   reg trig_prev_r;
   wire trig_sel = trig_r[`CTSIM_TRIG_SRC] ? cc2_s[1] : cc1_s[1];
   wire trig_act = trig_r[`CTSIM_TRIG_POL] ? trig_sel : ~trig_sel;
   wire trig_edge = trig_act & ~trig_prev_r;
   always @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         cc1_s <= 2'b00;
         cc2_s <= 2'b00;
         ser_s <= 2'b11;
         trig_prev_r <= 1'b1;
         ser_to_grabber <= 1'b1;
      end else begin
         cc1_s <= {cc1_s[0], cam_ctrl1};
         cc2_s <= {cc2_s[0], cam_ctrl2};
         ser_s <= {ser_s[0], ser_from_grabber};
         trig_prev_r <= trig_act;
         ser_to_grabber <= uart_r ? ser_s[1] : 1'b1;
      end
   end
   // ------------------------------------------------------------
   // Frame sequencer
   // ------------------------------------------------------------
   localparam ST_HALT = 3'b001;
   localparam ST_WAIT = 3'b010;
   localparam ST_RUN = 3'b100;
   wire halt = cfg_r[`CTSIM_CFG_FIFO_RESET];
   wire line_end = (pix_cnt_r == line_len_r - 16'h0001);
   wire frame_end = line_end & (line_cnt_r == frame_lines_r - 16'h0001);
   always @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         state_r <= ST_HALT;
         pix_cnt_r <= 16'h0000;
         line_cnt_r <= 16'h0000;
         trig_seen_r <= 1'b0;
         running <= 1'b0;
         fifo_flush <= 1'b1;
         line_valid <= 1'b0;
         frame_valid <= 1'b0;
         addr_r <= {TAPS*AW{1'b0}};
      end else begin
         fifo_flush <= halt;
         if (trig_edge) begin
            trig_seen_r <= 1'b1;
         end
         case (state_r)
            ST_HALT: begin
               running <= 1'b0;
               line_valid <= 1'b0;
               frame_valid <= 1'b0;
               if (!halt) begin
                  pix_cnt_r <= 16'h0000;
                  line_cnt_r <= 16'h0000;
                  state_r <= ST_WAIT;
               end
            end
            ST_WAIT: begin
               line_valid <= 1'b0;
               running <= 1'b1;
               addr_r <= start_r;
               if (halt) begin
                  state_r <= ST_HALT;
               end else if ((line_cnt_r == 16'h0000 && trig_r[`CTSIM_TRIG_FRAME]) ||
                            trig_r[`CTSIM_TRIG_LINE]) begin
                  frame_valid <= frame_valid & (line_cnt_r != 16'h0000);
                  if (trig_edge) begin
                     trig_seen_r <= 1'b0;
                     state_r <= ST_RUN;
                  end
               end else begin
                  state_r <= ST_RUN;
               end
            end
            ST_RUN: begin
               line_valid <= 1'b1;
               frame_valid <= 1'b1;
               for (adv_k = 0; adv_k < TAPS; adv_k = adv_k + 1) begin
                  addr_r[adv_k*AW +: AW] <= addr_r[adv_k*AW +: AW] + inc_r[adv_k*AW +: AW];
               end
               if (halt) begin
                  state_r <= ST_HALT;
               end else if (line_end) begin
                  pix_cnt_r <= 16'h0000;
                  line_cnt_r <= frame_end ? 16'h0000 : line_cnt_r + 16'h0001;
                  state_r <= ST_WAIT;
               end else begin
                  pix_cnt_r <= pix_cnt_r + 16'h0001;
               end
            end
            default: state_r <= ST_HALT;
         endcase
      end
   end
   always @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         pix_data <= {TAPS*8{1'b0}};
      end else begin
         pix_data <= mem_rdata;
      end
   end
   ctsim_tap_mem #(.AW(AW), .TAPS(TAPS)) u_mem (
      .hclk(hclk),
      .we(pix_we),
      .waddr(pix_waddr),
      .wdata(pix_wdata),
      .raddr(addr_r),
      .rdata(mem_rdata)
   );
endmodule
`default_nettype wire

// ==== design/ctsim_defines.vh ====
// Register map, field positions and reset values of the camera simulator control block
`ifndef CTSIM_DEFINES_VH
`define CTSIM_DEFINES_VH
`define CTSIM_OFF_CFG 8'h00
`define CTSIM_OFF_TRIG 8'h04
`define CTSIM_OFF_UART 8'h08
`define CTSIM_OFF_STATUS 8'h0C
`define CTSIM_OFF_TAP0 8'h10
`define CTSIM_OFF_TAP1 8'h14
`define CTSIM_OFF_TAP2 8'h18
`define CTSIM_OFF_TAP3 8'h1C
`define CTSIM_CFG_FIFO_RESET 3
`define CTSIM_CFG_RESET_VAL 8'h08
`define CTSIM_TRIG_POL 0
`define CTSIM_TRIG_SRC 1
`define CTSIM_TRIG_FRAME 2
`define CTSIM_TRIG_LINE 3
`define CTSIM_TRIG_RESET_VAL 4'h1
`define CTSIM_UART_LOOP 0
`define CTSIM_TAP_START_LSB 0
`define CTSIM_TAP_INC_LSB 16
`define CTSIM_LINE_LEN_DEF 16'h0100
`define CTSIM_FRAME_LINES_DEF 16'h0100
`endif

// ==== design/ctsim_tap_mem.v ====
// Raster buffer of 8-bit pixels, one write port and one registered read port per tap
`default_nettype none
module ctsim_tap_mem #(
   parameter AW = 12,
   parameter TAPS = 4
) (
   input wire hclk,
   input wire we,
   input wire [AW-1:0] waddr,
   input wire [7:0] wdata,
   input wire [TAPS*AW-1:0] raddr,
   output reg [TAPS*8-1:0] rdata
);
   reg [7:0] mem [0:(1<<AW)-1];
   integer i;
   always @(posedge hclk) begin
      if (we) begin
         mem[waddr] <= wdata;
      end
      for (i = 0; i < TAPS; i = i + 1) begin
         rdata[i*8 +: 8] <= mem[raddr[i*AW +: AW]];
      end
   end
endmodule
`default_nettype wire
